// ### common/subframe_timing_pkg.sv
package subframe_timing_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [7:0] IDX_ILLUM_END = 8'h90;
    localparam logic [7:0] IDX_CALC_START = 8'h91;
    localparam logic [7:0] IDX_CALC_END = 8'h92;
    localparam logic [7:0] IDX_PDN_START = 8'h93;
    localparam logic [7:0] IDX_PDN_END = 8'h94;
    localparam logic [7:0] IDX_SEQ_MASK = 8'h97;
    localparam logic [7:0] IDX_CAP_MASK = 8'h98;
    localparam logic [7:0] IDX_OVL_MASK = 8'h99;
    localparam logic [7:0] IDX_ILLUM_START = 8'h8F;
    localparam logic [7:0] IDX_SEQ_START = 8'h85;
    localparam logic [7:0] IDX_SEQ_END = 8'h86;
    localparam logic [7:0] IDX_CONTROL = 8'hA0;
    localparam logic [7:0] IDX_STATUS = 8'hA1;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int POS_LSB = 0;
    localparam int POS_W = 16;
    localparam int MASK_FIRST_LSB = 0;
    localparam int MASK_LAST_LSB = 12;
    localparam int MASK_W = 12;
    localparam int REG_W = 24;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] RST_ILLUM_START = 16'h0000;
    localparam logic [15:0] RST_ILLUM_END = 16'h2134;
    localparam logic [15:0] RST_CALC_START = 16'h2134;
    localparam logic [15:0] RST_CALC_END = 16'h2EE0;
    localparam logic [15:0] RST_PDN_START = 16'h0000;
    localparam logic [15:0] RST_PDN_END = 16'hFFFF;
    localparam logic [15:0] RST_SEQ_START = 16'h0020;
    localparam logic [15:0] RST_SEQ_END = 16'h0028;
    localparam logic [23:0] RST_SEQ_MASK = 24'h000000;
    localparam logic [23:0] RST_CAP_MASK = 24'h000000;
    localparam logic [23:0] RST_OVL_MASK = 24'h000001;
    localparam logic [15:0] RST_SUBFRAME_LEN = 16'h3000;
    localparam logic [11:0] RST_FRAME_LEN = 12'h004;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] startCount;
        logic [15:0] endCount;
    } window_s;

    typedef struct packed {
        logic [11:0] lastSub;
        logic [11:0] firstSub;
    } submask_s;

    typedef struct packed {
        logic illumEnable;
        logic calcWindow;
        logic powerDown;
        logic seqIrq;
        logic capture;
    } tg_out_s;

endpackage

// ### hdl/window_gate.sv
module window_gate (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [15:0] clkCount,
    input wire logic [11:0] subCount,
    input wire subframe_timing_pkg::window_s win,
    input wire subframe_timing_pkg::submask_s mask,
    input wire logic useMask,
    output logic sigOut
);
    typedef struct packed {
        logic out;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // ----------------------------------------
    // Window and sub-frame mask test
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.out = (clkCount >= win.startCount) && (clkCount < win.endCount)
            && (!useMask || ((subCount >= mask.firstSub) && (subCount <= mask.lastSub)));
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sigOut = state_reg.out;
endmodule

// ### hdl/subframe_counter.sv
module subframe_counter (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic run,
    input wire logic [15:0] subframeLen,
    input wire logic [11:0] frameLen,
    output logic [15:0] clkCount,
    output logic [11:0] subCount
);
    typedef struct packed {
        logic [15:0] clk;
        logic [11:0] sub;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // ----------------------------------------
    // Clock count within sub-frame, sub-frame within frame
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        if (!run) begin
            state_next = '0;
        end else if (state_reg.clk >= subframeLen - 16'h0001) begin
            state_next.clk = 16'h0000;
            if (state_reg.sub >= frameLen - 12'h001) begin
                state_next.sub = 12'h000;
            end else begin
                state_next.sub = state_reg.sub + 12'h001;
            end
        end else begin
            state_next.clk = state_reg.clk + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign clkCount = state_reg.clk;
    assign subCount = state_reg.sub;
endmodule

// ### hdl/subframe_timing_window_regs.sv
// Summary of operation
// RULE1 - Illumination enable ends at programmed count
// RULE2 - Calculation window starts at programmed count
// RULE3 - Calculation window ends at programmed count
// RULE4 - Power-down window starts at programmed count
// RULE5 - Power-down window ends at programmed count
// RULE6 - Sequencer interrupt last allowed sub-frame field
// RULE7 - Sequencer interrupt first allowed sub-frame field
// RULE8 - Masked signals only between mask sub-frames
// RULE9 - Capture last allowed sub-frame field
// RULE10 - Capture first allowed sub-frame field
// RULE11 - Software sets capture mask to averaged count
// RULE12 - Reserved bits 23:16 read as zero
// RULE13 - Illumination enable starts at programmed count
// RULE14 - Sequencer interrupt window between programmed counts
// RULE15 - Active from start count until end count
module subframe_timing_window_regs (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output subframe_timing_pkg::tg_out_s tgOut
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] illumStart;
        logic [15:0] illumEnd;
        logic [15:0] calcStart;
        logic [15:0] calcEnd;
        logic [15:0] pdnStart;
        logic [15:0] pdnEnd;
        logic [15:0] seqStart;
        logic [15:0] seqEnd;
        logic [23:0] seqMask;
        logic [23:0] capMask;
        logic [23:0] ovlMask;
        logic run;
        logic [15:0] subframeLen;
        logic [11:0] frameLen;
        logic [31:0] rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic [15:0] clkCount;
    logic [11:0] subCount;
    logic access;
    logic [7:0] idx;
    logic hit;

    // ----------------------------------------
    // Byte-lane merge for writes
    // ----------------------------------------
    function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [23:0] res;
        res = old;
        for (int i = 0; i < 3; i++) begin
            if (st[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_mapped(input logic [7:0] ix);
        return ix == subframe_timing_pkg::IDX_ILLUM_START || ix == subframe_timing_pkg::IDX_ILLUM_END
            || ix == subframe_timing_pkg::IDX_CALC_START || ix == subframe_timing_pkg::IDX_CALC_END
            || ix == subframe_timing_pkg::IDX_PDN_START || ix == subframe_timing_pkg::IDX_PDN_END
            || ix == subframe_timing_pkg::IDX_SEQ_START || ix == subframe_timing_pkg::IDX_SEQ_END
            || ix == subframe_timing_pkg::IDX_SEQ_MASK || ix == subframe_timing_pkg::IDX_CAP_MASK
            || ix == subframe_timing_pkg::IDX_OVL_MASK || ix == subframe_timing_pkg::IDX_CONTROL
            || ix == subframe_timing_pkg::IDX_STATUS;
    endfunction

    assign access = psel && penable;
    assign idx = paddr[9:2];
    assign hit = is_mapped(idx) && (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);

    // ----------------------------------------
    // Register file and APB slave
    // ----------------------------------------
    always_comb begin
        logic [23:0] m;
        m = 24'h000000;
        state_next = state_reg;
        if (access && pwrite && hit) begin
            case (idx)
                subframe_timing_pkg::IDX_ILLUM_START: begin
                    m = merge({8'h00, state_reg.illumStart}, pwdata, pstrb);
                    state_next.illumStart = m[15:0]; // [RULE13] [RULE12]
                end
                subframe_timing_pkg::IDX_ILLUM_END: begin
                    m = merge({8'h00, state_reg.illumEnd}, pwdata, pstrb);
                    state_next.illumEnd = m[15:0]; // [RULE1]
                end
                subframe_timing_pkg::IDX_CALC_START: begin
                    m = merge({8'h00, state_reg.calcStart}, pwdata, pstrb);
                    state_next.calcStart = m[15:0]; // [RULE2]
                end
                subframe_timing_pkg::IDX_CALC_END: begin
                    m = merge({8'h00, state_reg.calcEnd}, pwdata, pstrb);
                    state_next.calcEnd = m[15:0]; // [RULE3]
                end
                subframe_timing_pkg::IDX_PDN_START: begin
                    m = merge({8'h00, state_reg.pdnStart}, pwdata, pstrb);
                    state_next.pdnStart = m[15:0]; // [RULE4]
                end
                subframe_timing_pkg::IDX_PDN_END: begin
                    m = merge({8'h00, state_reg.pdnEnd}, pwdata, pstrb);
                    state_next.pdnEnd = m[15:0]; // [RULE5]
                end
                subframe_timing_pkg::IDX_SEQ_START: begin
                    m = merge({8'h00, state_reg.seqStart}, pwdata, pstrb);
                    state_next.seqStart = m[15:0]; // [RULE14]
                end
                subframe_timing_pkg::IDX_SEQ_END: begin
                    m = merge({8'h00, state_reg.seqEnd}, pwdata, pstrb);
                    state_next.seqEnd = m[15:0]; // [RULE14]
                end
                subframe_timing_pkg::IDX_SEQ_MASK: begin
                    state_next.seqMask = merge(state_reg.seqMask, pwdata, pstrb); // [RULE6] [RULE7]
                end
                subframe_timing_pkg::IDX_CAP_MASK: begin
                    state_next.capMask = merge(state_reg.capMask, pwdata, pstrb); // [RULE9] [RULE10]
                end
                subframe_timing_pkg::IDX_OVL_MASK: begin
                    state_next.ovlMask = merge(state_reg.ovlMask, pwdata, pstrb);
                end
                subframe_timing_pkg::IDX_CONTROL: begin
                    if (pstrb[0]) begin
                        state_next.run = pwdata[0];
                    end
                    if (pstrb[1]) begin
                        state_next.frameLen = {4'h0, pwdata[15:8]};
                    end
                    if (pstrb[2] && pstrb[3]) begin
                        state_next.subframeLen = pwdata[31:16];
                    end
                end
                default: begin
                end
            endcase
        end
        if (psel && !penable && !pwrite) begin
            case (idx)
                subframe_timing_pkg::IDX_ILLUM_START: state_next.rdata = {16'h0000, state_reg.illumStart}; // [RULE12]
                subframe_timing_pkg::IDX_ILLUM_END: state_next.rdata = {16'h0000, state_reg.illumEnd};
                subframe_timing_pkg::IDX_CALC_START: state_next.rdata = {16'h0000, state_reg.calcStart};
                subframe_timing_pkg::IDX_CALC_END: state_next.rdata = {16'h0000, state_reg.calcEnd};
                subframe_timing_pkg::IDX_PDN_START: state_next.rdata = {16'h0000, state_reg.pdnStart};
                subframe_timing_pkg::IDX_PDN_END: state_next.rdata = {16'h0000, state_reg.pdnEnd};
                subframe_timing_pkg::IDX_SEQ_START: state_next.rdata = {16'h0000, state_reg.seqStart};
                subframe_timing_pkg::IDX_SEQ_END: state_next.rdata = {16'h0000, state_reg.seqEnd};
                subframe_timing_pkg::IDX_SEQ_MASK: state_next.rdata = {8'h00, state_reg.seqMask};
                subframe_timing_pkg::IDX_CAP_MASK: state_next.rdata = {8'h00, state_reg.capMask};
                subframe_timing_pkg::IDX_OVL_MASK: state_next.rdata = {8'h00, state_reg.ovlMask};
                subframe_timing_pkg::IDX_CONTROL:
                    state_next.rdata = {state_reg.subframeLen, state_reg.frameLen[7:0], 7'h00, state_reg.run};
                subframe_timing_pkg::IDX_STATUS: state_next.rdata = {4'h0, subCount, clkCount};
                default: state_next.rdata = 32'h00000000;
            endcase
            if (!hit) begin
                state_next.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg.illumStart <= subframe_timing_pkg::RST_ILLUM_START;
            state_reg.illumEnd <= subframe_timing_pkg::RST_ILLUM_END;
            state_reg.calcStart <= subframe_timing_pkg::RST_CALC_START;
            state_reg.calcEnd <= subframe_timing_pkg::RST_CALC_END;
            state_reg.pdnStart <= subframe_timing_pkg::RST_PDN_START;
            state_reg.pdnEnd <= subframe_timing_pkg::RST_PDN_END;
            state_reg.seqStart <= subframe_timing_pkg::RST_SEQ_START;
            state_reg.seqEnd <= subframe_timing_pkg::RST_SEQ_END;
            state_reg.seqMask <= subframe_timing_pkg::RST_SEQ_MASK;
            state_reg.capMask <= subframe_timing_pkg::RST_CAP_MASK;
            state_reg.ovlMask <= subframe_timing_pkg::RST_OVL_MASK;
            state_reg.run <= 1'b0;
            state_reg.subframeLen <= subframe_timing_pkg::RST_SUBFRAME_LEN;
            state_reg.frameLen <= subframe_timing_pkg::RST_FRAME_LEN;
            state_reg.rdata <= 32'h00000000;
        end else begin
            state_reg <= state_next;
        end
    end

    // Read data captured in setup, stands through access
    assign prdata = state_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    // ----------------------------------------
    // Counters and signal windows
    // ----------------------------------------
    subframe_counter u_counter (
        .clk_sys(clk_sys),
        .srst(srst),
        .run(state_reg.run),
        .subframeLen(state_reg.subframeLen),
        .frameLen(state_reg.frameLen),
        .clkCount(clkCount),
        .subCount(subCount)
    );

    localparam subframe_timing_pkg::submask_s NO_MASK = '0;

    window_gate u_illum (
        .clk_sys(clk_sys), .srst(srst), .clkCount(clkCount), .subCount(subCount),
        .win({state_reg.illumStart, state_reg.illumEnd}), .mask(NO_MASK), .useMask(1'b0),
        .sigOut(tgOut.illumEnable) // [RULE1] [RULE13] [RULE15]
    );
    window_gate u_calc (
        .clk_sys(clk_sys), .srst(srst), .clkCount(clkCount), .subCount(subCount),
        .win({state_reg.calcStart, state_reg.calcEnd}), .mask(NO_MASK), .useMask(1'b0),
        .sigOut(tgOut.calcWindow) // [RULE2] [RULE3]
    );
    window_gate u_pdn (
        .clk_sys(clk_sys), .srst(srst), .clkCount(clkCount), .subCount(subCount),
        .win({state_reg.pdnStart, state_reg.pdnEnd}), .mask(NO_MASK), .useMask(1'b0),
        .sigOut(tgOut.powerDown) // [RULE4] [RULE5]
    );
    window_gate u_seq (
        .clk_sys(clk_sys), .srst(srst), .clkCount(clkCount), .subCount(subCount),
        .win({state_reg.seqStart, state_reg.seqEnd}), .mask(state_reg.seqMask), .useMask(1'b1),
        .sigOut(tgOut.seqIrq) // [RULE14] [RULE6] [RULE7] [RULE8]
    );
    window_gate u_cap (
        .clk_sys(clk_sys), .srst(srst), .clkCount(clkCount), .subCount(subCount),
        .win({state_reg.calcStart, state_reg.calcEnd}), .mask(state_reg.capMask), .useMask(1'b1),
        .sigOut(tgOut.capture) // [RULE9] [RULE10] [RULE8]
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (srst) // [RULE12]
        access && !pwrite && hit && idx == subframe_timing_pkg::IDX_CALC_END |-> prdata[31:16] == 16'h0000)
        else $error("reserved bits not zero");
    chk_illum_window: assert property (@(posedge clk_sys) disable iff (srst) // [RULE15]
        (clkCount >= state_reg.illumStart && clkCount < state_reg.illumEnd && $stable(state_reg.illumEnd))
        |=> tgOut.illumEnable)
        else $error("illumination enable missing in window");
    chk_illum_end: assert property (@(posedge clk_sys) disable iff (srst) // [RULE1]
        clkCount >= state_reg.illumEnd && $stable(state_reg.illumEnd) |=> !tgOut.illumEnable)
        else $error("illumination enable past end");
    chk_calc_start: assert property (@(posedge clk_sys) disable iff (srst) // [RULE2]
        clkCount < state_reg.calcStart && $stable(state_reg.calcStart) |=> !tgOut.calcWindow)
        else $error("calc window before start");
    chk_calc_end: assert property (@(posedge clk_sys) disable iff (srst) // [RULE3]
        clkCount >= state_reg.calcEnd && $stable(state_reg.calcEnd) |=> !tgOut.calcWindow)
        else $error("calc window past end");
    chk_pdn_start: assert property (@(posedge clk_sys) disable iff (srst) // [RULE4]
        clkCount < state_reg.pdnStart && $stable(state_reg.pdnStart) |=> !tgOut.powerDown)
        else $error("power-down before start");
    chk_pdn_end: assert property (@(posedge clk_sys) disable iff (srst) // [RULE5]
        clkCount >= state_reg.pdnEnd && $stable(state_reg.pdnEnd) |=> !tgOut.powerDown)
        else $error("power-down past end");
    chk_seq_mask_last: assert property (@(posedge clk_sys) disable iff (srst) // [RULE6]
        subCount > state_reg.seqMask[23:12] && $stable(state_reg.seqMask) |=> !tgOut.seqIrq)
        else $error("seq irq after last sub-frame");
    chk_seq_mask_first: assert property (@(posedge clk_sys) disable iff (srst) // [RULE7]
        subCount < state_reg.seqMask[11:0] && $stable(state_reg.seqMask) |=> !tgOut.seqIrq)
        else $error("seq irq before first sub-frame");
    chk_cap_mask_range: assert property (@(posedge clk_sys) disable iff (srst) // [RULE8]
        (subCount < state_reg.capMask[11:0] || subCount > state_reg.capMask[23:12]) && $stable(state_reg.capMask)
        |=> !tgOut.capture)
        else $error("capture outside mask");
    chk_seq_window: assert property (@(posedge clk_sys) disable iff (srst) // [RULE14]
        clkCount < state_reg.seqStart && $stable(state_reg.seqStart) |=> !tgOut.seqIrq)
        else $error("seq irq before start count");
    chk_write_lands: assert property (@(posedge clk_sys) disable iff (srst) // [RULE9]
        access && pwrite && hit && idx == subframe_timing_pkg::IDX_CAP_MASK && pstrb == 4'hF
        |=> state_reg.capMask == $past(pwdata[23:0]))
        else $error("capture mask write lost");
    chk_first_lands: assert property (@(posedge clk_sys) disable iff (srst) // [RULE10]
        access && pwrite && hit && idx == subframe_timing_pkg::IDX_CAP_MASK && pstrb[0] && pstrb[1]
        |=> state_reg.capMask[11:0] == $past(pwdata[11:0]))
        else $error("capture first field write lost");
    chk_start_lands: assert property (@(posedge clk_sys) disable iff (srst) // [RULE13]
        access && pwrite && hit && idx == subframe_timing_pkg::IDX_ILLUM_START && pstrb == 4'hF
        |=> state_reg.illumStart == $past(pwdata[15:0]))
        else $error("illumination start write lost");

    chk_illum_start: assert property (@(posedge clk_sys) disable iff (srst) // [RULE13]
        clkCount < state_reg.illumStart |=> !tgOut.illumEnable)
        else $error("illumination enable before start");

    chk_calc_inside: assert property (@(posedge clk_sys) disable iff (srst) // [RULE15]
        clkCount >= state_reg.calcStart && clkCount < state_reg.calcEnd |=> tgOut.calcWindow)
        else $error("calc window missing");

    chk_pdn_inside: assert property (@(posedge clk_sys) disable iff (srst) // [RULE15]
        clkCount >= state_reg.pdnStart && clkCount < state_reg.pdnEnd |=> tgOut.powerDown)
        else $error("power-down missing");

    chk_seq_end: assert property (@(posedge clk_sys) disable iff (srst) // [RULE14]
        clkCount >= state_reg.seqEnd |=> !tgOut.seqIrq)
        else $error("seq irq past end count");

    chk_seq_inside: assert property (@(posedge clk_sys) disable iff (srst) // [RULE8]
        clkCount >= state_reg.seqStart && clkCount < state_reg.seqEnd
        && subCount >= state_reg.seqMask[11:0] && subCount <= state_reg.seqMask[23:12] |=> tgOut.seqIrq)
        else $error("seq irq missing in allowed sub-frame");

    chk_cap_inside: assert property (@(posedge clk_sys) disable iff (srst) // [RULE8]
        clkCount >= state_reg.calcStart && clkCount < state_reg.calcEnd
        && subCount >= state_reg.capMask[11:0] && subCount <= state_reg.capMask[23:12] |=> tgOut.capture)
        else $error("capture missing in allowed sub-frame");

    chk_seq_lands: assert property (@(posedge clk_sys) disable iff (srst) // [RULE6]
        access && pwrite && hit && idx == subframe_timing_pkg::IDX_SEQ_MASK && pstrb == 4'hF
        |=> state_reg.seqMask == $past(pwdata[23:0]))
        else $error("seq mask write lost");

    chk_end_lands: assert property (@(posedge clk_sys) disable iff (srst) // [RULE1]
        access && pwrite && hit && idx == subframe_timing_pkg::IDX_ILLUM_END && pstrb == 4'hF
        |=> state_reg.illumEnd == $past(pwdata[15:0]))
        else $error("illumination end write lost");

    chk_calc_lands: assert property (@(posedge clk_sys) disable iff (srst) // [RULE2]
        access && pwrite && hit && idx == subframe_timing_pkg::IDX_CALC_START && pstrb == 4'hF
        |=> state_reg.calcStart == $past(pwdata[15:0]))
        else $error("calc start write lost");

    chk_reserved_read: assert property (@(posedge clk_sys) disable iff (srst) // [RULE12]
        access && !pwrite && hit && idx == subframe_timing_pkg::IDX_ILLUM_END |-> prdata[31:16] == 16'h0000)
        else $error("reserved bits not zero on read");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    cov_read_access: cover property (@(posedge clk_sys) access && !pwrite && hit);
    cov_illum: cover property (@(posedge clk_sys) $rose(tgOut.illumEnable));
    cov_seq: cover property (@(posedge clk_sys) $rose(tgOut.seqIrq));
    cov_capture: cover property (@(posedge clk_sys) $rose(tgOut.capture));
    cov_bad_addr: cover property (@(posedge clk_sys) pslverr);
endmodule

// ### verif/subframe_timing_window_regs_tb.sv
module subframe_timing_window_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    subframe_timing_pkg::tg_out_s tgOut;
    int num_errors = 0;
    int checks = 0;
    logic lastErr;
    logic [31:0] rd;

    subframe_timing_window_regs DUT (
        .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tgOut(tgOut)
    );

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Common tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] exp, input logic [31:0] act);
        checks++;
        if (act !== exp) begin
            num_errors++;
            $display("ERROR at %0t: expected %h, got %h", $time, exp, act);
        end
    endtask

    // Setup cycle, access held until pready, read data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] data);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        lastErr = pslverr;
        data = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        @(posedge clk_sys);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_values;
        logic [7:0] ix [11];
        logic [31:0] ex [11];
        ix = '{8'h8F, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h85, 8'h86, 8'h97, 8'h98, 8'h99};
        ex = '{32'h0, 32'h2134, 32'h2134, 32'h2EE0, 32'h0, 32'hFFFF, 32'h20, 32'h28, 32'h0, 32'h0, 32'h1};
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, ix[i], 32'h0, rd);
            check(ex[i], rd);
        end
        $display("Test reset values done");
    endtask

    task automatic test_reserved_and_unmapped;
        apb(1'b1, 8'h92, 32'h0000FFFF, rd);
        apb(1'b0, 8'h92, 32'h0, rd);
        check(32'h0000FFFF, rd);
        apb(1'b1, 8'h98, 32'hFFFFFFFF, rd);
        apb(1'b0, 8'h98, 32'h0, rd);
        check(32'h00FFFFFF, rd);
        apb(1'b0, 8'h95, 32'h0, rd);
        check({31'h0, 1'b1}, {31'h0, lastErr});
        check(32'h0, rd);
        $display("Test reserved and unmapped done");
    endtask

    task automatic test_windows;
        int cnt [5];
        apb(1'b1, 8'h8F, 32'h10, rd);
        apb(1'b1, 8'h90, 32'h20, rd);
        apb(1'b1, 8'h91, 32'h08, rd);
        apb(1'b1, 8'h92, 32'h30, rd);
        apb(1'b1, 8'h93, 32'h05, rd);
        apb(1'b1, 8'h94, 32'h0A, rd);
        apb(1'b1, 8'h97, 32'h002001, rd);
        apb(1'b1, 8'h98, 32'h003002, rd);
        apb(1'b0, 8'h97, 32'h0, rd);
        check(32'h002001, rd);
        // Four sub-frames of 40h clocks, counters running
        apb(1'b1, 8'hA0, 32'h00400401, rd);
        repeat (300) @(posedge clk_sys);
        cnt = '{0, 0, 0, 0, 0};
        for (int c = 0; c < 512; c++) begin
            @(negedge clk_sys);
            cnt[0] += int'(tgOut.illumEnable === 1'b1);
            cnt[1] += int'(tgOut.calcWindow === 1'b1);
            cnt[2] += int'(tgOut.powerDown === 1'b1);
            cnt[3] += int'(tgOut.seqIrq === 1'b1);
            cnt[4] += int'(tgOut.capture === 1'b1);
        end
        check(32'd128, cnt[0]);
        check(32'd320, cnt[1]);
        check(32'd40, cnt[2]);
        check(32'd32, cnt[3]);
        check(32'd160, cnt[4]);
        apb(1'b1, 8'h98, 32'h002002, rd);
        cnt[4] = 0;
        for (int c = 0; c < 512; c++) begin
            @(negedge clk_sys);
            cnt[4] += int'(tgOut.capture === 1'b1);
        end
        check(32'd80, cnt[4]);
        $display("Test windows done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        test_reset_values();
        test_reserved_and_unmapped();
        test_windows();
        stop_test();
    end
endmodule
